// File: hdl/fsp_ctrl.sv
// Host controller that drives the flash pins for protected access.
`timescale 1ns/1ps
module fsp_ctrl (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire logic [3:0]            i_addr,
	input  wire logic [31:0]           i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [31:0]           o_rdata,
	input  wire logic                  i_supply_low,
	input  wire logic [15:0]           i_dq,
	output logic      [15:0]           o_dq,
	output logic                       o_dq_oe,
	output logic      [21:0]           o_flash_addr,
	output logic                       o_ce_n,
	output logic                       o_we_n,
	output logic                       o_oe_n,
	output logic                       o_reset_n,
	output logic                       o_reset_elevated,
	output logic                       o_protect_accel_pin
);
	// ========================================================================
	// Synchronisers for asynchronous inputs
	logic [15:0] dq_s1_r, dq_s2_r;
	logic        low_s1_r, low_s2_r;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			dq_s1_r  <= 16'h0000;
			dq_s2_r  <= 16'h0000;
			low_s1_r <= 1'b1;
			low_s2_r <= 1'b1;
		end else begin
			dq_s1_r  <= i_dq;
			dq_s2_r  <= dq_s1_r;
			low_s1_r <= i_supply_low;
			low_s2_r <= low_s1_r;
		end
	end

	// ========================================================================
	// Cycle state machine
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_SETUP = 4'b0010,
		S_PULSE = 4'b0100,
		S_HOLD  = 4'b1000
	} fsp_state_t;

	fsp_state_t          state_r, state_nxt;
	logic                is_wr_r, is_wr_nxt;
	logic [3:0]          cnt_r, cnt_nxt;
	logic [21:0]         addr_r, addr_nxt;
	logic [15:0]         wdata_r, wdata_nxt;
	logic [15:0]         rdata_r, rdata_nxt;
	logic [2:0]          pins_r, pins_nxt;
	logic                done_r, done_nxt;
	logic                inh_r, inh_nxt;
	fsp_pkg::fsp_ctl_t   ctl_r, ctl_nxt;
	logic                go_rd, go_wr, busy;

	assign busy  = (state_r != S_IDLE);
	// Software issues every command sequence, the secure-region exit too,
	// as single cycles; this block never reorders or merges them.
	assign go_rd = i_wr && (i_addr == fsp_pkg::REG_CTRL)
		&& i_wdata[fsp_pkg::CTRL_GO_READ];
	assign go_wr = i_wr && (i_addr == fsp_pkg::REG_CTRL)
		&& i_wdata[fsp_pkg::CTRL_GO_WRITE]
		&& !i_wdata[fsp_pkg::CTRL_GO_READ];

	always_comb begin
		state_nxt = state_r;
		is_wr_nxt = is_wr_r;
		cnt_nxt   = cnt_r;
		addr_nxt  = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		pins_nxt  = pins_r;
		done_nxt  = done_r;
		inh_nxt   = inh_r;
		ctl_nxt   = ctl_r;
		if (i_wr && !busy) begin
			unique case (i_addr)
				fsp_pkg::REG_ADDR:  addr_nxt  = i_wdata[21:0];
				fsp_pkg::REG_WDATA: wdata_nxt = i_wdata[15:0];
				// Elevated reset enters and leaves unprotect mode.
				fsp_pkg::REG_PINS:  pins_nxt  = i_wdata[2:0];
				default: ;
			endcase
		end
		if (i_rd && i_addr == fsp_pkg::REG_STATUS)
			done_nxt = 1'b0;
		unique case (state_r)
			S_IDLE: begin
				ctl_nxt = fsp_pkg::CTL_IDLE;
				// Writes are dropped while supply is low.
				if (go_wr && low_s2_r) begin
					inh_nxt  = 1'b1;
					done_nxt = 1'b1;
				end else if (go_rd || go_wr) begin
					is_wr_nxt = go_wr;
					inh_nxt   = 1'b0;
					cnt_nxt   = 4'(fsp_pkg::SETUP_CYC);
					state_nxt = S_SETUP;
					// Chip select first, output enable high for writes.
					ctl_nxt.ce_n = 1'b0;
				end
			end
			S_SETUP: begin
				cnt_nxt = cnt_r - fsp_pkg::CNT_W1;
				if (cnt_r == fsp_pkg::CNT_W1) begin
					cnt_nxt   = 4'(fsp_pkg::PULSE_CYC);
					state_nxt = S_PULSE;
					if (is_wr_r)
						ctl_nxt.we_n = 1'b0;
					else
						ctl_nxt.oe_n = 1'b0;
				end
			end
			S_PULSE: begin
				// Pulse lasts well past the glitch filter width.
				cnt_nxt = cnt_r - fsp_pkg::CNT_W1;
				if (cnt_r == fsp_pkg::CNT_W1) begin
					if (!is_wr_r)
						rdata_nxt = dq_s2_r;
					ctl_nxt.we_n = 1'b1;
					ctl_nxt.oe_n = 1'b1;
					state_nxt    = S_HOLD;
				end
			end
			S_HOLD: begin
				ctl_nxt   = fsp_pkg::CTL_IDLE;
				done_nxt  = 1'b1;
				state_nxt = S_IDLE;
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= S_IDLE;
			is_wr_r <= 1'b0;
			cnt_r   <= 4'h0;
			addr_r  <= 22'h000000;
			wdata_r <= 16'h0000;
			rdata_r <= 16'h0000;
			pins_r  <= fsp_pkg::PINS_RST_VAL;
			done_r  <= 1'b0;
			inh_r   <= 1'b0;
			ctl_r   <= fsp_pkg::CTL_IDLE;
		end else begin
			state_r <= state_nxt;
			is_wr_r <= is_wr_nxt;
			cnt_r   <= cnt_nxt;
			addr_r  <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			pins_r  <= pins_nxt;
			done_r  <= done_nxt;
			inh_r   <= inh_nxt;
			ctl_r   <= ctl_nxt;
		end
	end

	// ========================================================================
	// Pin drive
	assign o_ce_n              = ctl_r.ce_n;
	assign o_we_n              = ctl_r.we_n;
	assign o_oe_n              = ctl_r.oe_n;
	assign o_flash_addr        = addr_r;
	assign o_dq                = wdata_r;
	// Data bus is driven only during write cycles so reads never contend.
	assign o_dq_oe             = busy && is_wr_r;
	assign o_reset_elevated    = pins_r[fsp_pkg::PIN_ELEV];
	// Write-protect level steers edge group protection.
	assign o_protect_accel_pin = pins_r[fsp_pkg::PIN_WP_N];
	assign o_reset_n           = pins_r[fsp_pkg::PIN_RESET_N];

	// ========================================================================
	// Register read port
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			unique case (i_addr)
				fsp_pkg::REG_ADDR:   o_rdata <= {10'h000, addr_r};
				fsp_pkg::REG_WDATA:  o_rdata <= {16'h0000, wdata_r};
				fsp_pkg::REG_RDATA:  o_rdata <= {16'h0000, rdata_r};
				fsp_pkg::REG_STATUS: o_rdata <= {28'h0000000,
					// Secure indicator bit of the last read word.
					rdata_r[fsp_pkg::SEC_BIT_IND], done_r, inh_r, busy};
				fsp_pkg::REG_PINS:   o_rdata <= {29'h00000000, pins_r};
				default:             o_rdata <= 32'h00000000;
			endcase
		end else begin
			o_rdata <= 32'h00000000;
		end
	end

	// ========================================================================
	// Checks
	property p_wr_qual;
		@(posedge i_clk) disable iff (i_rst)
		!o_we_n |-> (!o_ce_n && o_oe_n);
	endproperty
	a_wr_qual: assert property (p_wr_qual) else $error("bad write qual");
	property p_pulse_len;
		@(posedge i_clk) disable iff (i_rst)
		$fell(o_we_n) |-> !o_we_n [*3];
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("we short");
	property p_low_inh;
		@(posedge i_clk) disable iff (i_rst)
		(go_wr && low_s2_r && !busy) |=> (!busy && o_we_n && inh_r);
	endproperty
	a_low_inh: assert property (p_low_inh) else $error("low write");
	property p_end;
		@(posedge i_clk) disable iff (i_rst)
		$rose(busy) |-> ##[4:6] !busy;
	endproperty
	a_end: assert property (p_end) else $error("cycle hung");
	property p_elev;
		@(posedge i_clk) disable iff (i_rst)
		(i_wr && !busy && i_addr == fsp_pkg::REG_PINS)
			|=> o_reset_elevated == $past(i_wdata[0]);
	endproperty
	a_elev: assert property (p_elev) else $error("elev pin");
	property p_wp;
		@(posedge i_clk) disable iff (i_rst)
		(i_wr && !busy && i_addr == fsp_pkg::REG_PINS)
			|=> o_protect_accel_pin == $past(i_wdata[1]);
	endproperty
	a_wp: assert property (p_wp) else $error("wp pin");
	// Chip select must lead and trail every enable pulse, or the flash
	// could latch a command on a half-formed cycle.
	property p_ce_lead;
		@(posedge i_clk) disable iff (i_rst)
		($fell(o_we_n) || $fell(o_oe_n)) |-> $past(!o_ce_n);
	endproperty
	a_ce_lead: assert property (p_ce_lead) else $error("ce late");
	property p_ce_trail;
		@(posedge i_clk) disable iff (i_rst)
		$rose(o_we_n) |-> !o_ce_n;
	endproperty
	a_ce_trail: assert property (p_ce_trail) else $error("ce early");
	property p_oe_pulse;
		@(posedge i_clk) disable iff (i_rst)
		$fell(o_oe_n) |-> !o_oe_n [*3];
	endproperty
	a_oe_pulse: assert property (p_oe_pulse) else $error("oe short");
	// Both sides driving the data wire would corrupt the word and stress
	// the pads, so output enable and data drive never overlap.
	property p_no_fight;
		@(posedge i_clk) disable iff (i_rst)
		o_dq_oe |-> o_oe_n;
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("dq fight");
	// Address and data registers take no writes while busy, so they hold still
	// for the whole cycle.
	property p_bus_hold;
		@(posedge i_clk) disable iff (i_rst)
		(busy && $past(busy))
			|-> ($stable(o_flash_addr) && $stable(o_dq));
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("bus moved");
	property p_low_quiet;
		@(posedge i_clk) disable iff (i_rst)
		(low_s2_r && !busy) |=> o_we_n;
	endproperty
	a_low_quiet: assert property (p_low_quiet) else $error("low we");
	c_write: cover property (@(posedge i_clk) $fell(o_we_n));
	c_read:  cover property (@(posedge i_clk) $fell(o_oe_n));
	c_inh:   cover property (@(posedge i_clk) $rose(inh_r));
	c_elev:  cover property (@(posedge i_clk) $rose(o_reset_elevated));
endmodule : fsp_ctrl

// File: hdl/fsp_pkg.sv
// Package of constants and carrier types for the flash protection controller.
package fsp_pkg;
	// ========================================================================
	// Bus and address widths
	localparam int ADDR_W     = 22;
	localparam int DATA_W     = 16;
	localparam int GROUP_LSB  = 15;
	localparam int GROUP_W    = 7;
	// ========================================================================
	// Software register offsets
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_ADDR    = 4'h1;
	localparam logic [3:0] REG_WDATA   = 4'h2;
	localparam logic [3:0] REG_RDATA   = 4'h3;
	localparam logic [3:0] REG_STATUS  = 4'h4;
	localparam logic [3:0] REG_PINS    = 4'h5;
	// Control register fields.
	localparam int CTRL_GO_READ   = 0;
	localparam int CTRL_GO_WRITE  = 1;
	// Pin control fields.
	localparam int PIN_ELEV       = 0;
	localparam int PIN_WP_N       = 1;
	localparam int PIN_RESET_N    = 2;
	localparam logic [2:0] PINS_RST_VAL = 3'h6;
	// Status fields.
	localparam int ST_BUSY        = 0;
	localparam int ST_INHIBIT     = 1;
	localparam int ST_DONE        = 2;
	localparam int ST_BIT7        = 3;
	// ========================================================================
	// Secure region layout (word addresses)
	localparam logic [21:0] SEC_SERIAL_LAST = 22'h000007;
	localparam logic [21:0] SEC_LAST        = 22'h00007F;
	localparam int          SEC_BIT_IND     = 7;
	// ========================================================================
	// Timing
	localparam int CLK_MHZ        = 10;
	localparam int GLITCH_NS      = 3;
	// Least time rounds up to one whole cycle.
	localparam int GLITCH_CYC     = (GLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int SETUP_CYC      = 1;
	localparam int PULSE_CYC      = 2 + GLITCH_CYC;
	localparam logic [3:0] CNT_W1 = 4'h1;
	// ========================================================================
	// Carrier of the flash control pins
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
	} fsp_ctl_t;
	localparam fsp_ctl_t CTL_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
endpackage : fsp_pkg

// File: testbench/fsp_ctrl_test.sv
// Self-checking bench of the flash protection controller.
`timescale 1ns/1ps
module fsp_ctrl_test;
	typedef struct {string n; logic [31:0] v; logic [31:0] m;} fsp_note_t;
	logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic i_supply_low = 1'b0, rd_chk = 1'b0, chk_d = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0, o_rdata, last_rd;
	logic [15:0] o_dq, mdl_dq, dq_bus;
	logic [21:0] o_flash_addr;
	logic o_dq_oe, o_ce_n, o_we_n, o_oe_n, o_reset_n, o_elev, o_wp;
	int n_mismatch = 0, n_checks = 0, n_we = 0, exp_we = 0;
	fsp_note_t q[$];
	fsp_note_t nt;
	logic [21:0] a;
	logic [15:0] d;
	logic [15:0] d_ok;
	logic [2:0] pins [4] = '{3'h6, 3'h7, 3'h6, 3'h5};
	logic [3:0] okw = 4'b0010;
	// ========================================================================
	// Design, device and the shared data wire
	assign dq_bus = o_dq_oe ? o_dq : mdl_dq;
	fsp_ctrl fsp_ctrl_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_supply_low(i_supply_low), .i_dq(dq_bus), .o_dq(o_dq),
		.o_dq_oe(o_dq_oe), .o_flash_addr(o_flash_addr), .o_ce_n(o_ce_n),
		.o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_reset_n(o_reset_n),
		.o_reset_elevated(o_elev), .o_protect_accel_pin(o_wp));
	fsp_flash_model fsp_flash_model_i (.i_ce_n(o_ce_n), .i_we_n(o_we_n),
		.i_oe_n(o_oe_n), .i_addr(o_flash_addr), .i_dq(dq_bus),
		.i_elevated(o_elev), .i_wp_n(o_wp), .i_supply_low(i_supply_low),
		.o_dq(mdl_dq));
	always #50 i_clk = ~i_clk;
	always @(negedge o_we_n) n_we++;
	always @(posedge i_clk) chk_d <= i_rd & rd_chk;
	always @(posedge i_clk) begin
		if (chk_d) begin
			nt = q.pop_front();
			cmp(nt.n, nt.v & nt.m, o_rdata & nt.m);
		end
	end
	task automatic cmp(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task automatic wr(input logic [3:0] ad, input logic [31:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] ad, input string n,
		input logic [31:0] v, input logic [31:0] m, input logic c);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= ad;
		rd_chk <= c;
		if (c)
			q.push_back('{n, v, m});
		@(posedge i_clk);
		i_rd <= 1'b0;
		rd_chk <= 1'b0;
		#1 last_rd = o_rdata;
	endtask : rd
	// Runs one flash cycle and polls busy under a bound.
	task automatic op(input logic [21:0] fa, input logic [15:0] fd,
		input logic w);
		int n;
		wr(fsp_pkg::REG_ADDR, {10'h000, fa});
		wr(fsp_pkg::REG_WDATA, {16'h0000, fd});
		wr(fsp_pkg::REG_CTRL, w ? 32'h2 : 32'h1);
		n = 0;
		last_rd = 32'h1;
		while (last_rd[fsp_pkg::ST_BUSY] !== 1'b0 && n < 40) begin
			rd(fsp_pkg::REG_STATUS, "", 32'h0, 32'h0, 1'b0);
			n++;
		end
		if (n >= 40) begin
			n_mismatch++;
			test_done();
		end
		if (w)
			exp_we++;
	endtask : op
	initial begin
		void'($urandom(32'h1f5a0074));
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(fsp_pkg::REG_PINS, "pins", 32'h6, 32'h7, 1'b1);
		rd(fsp_pkg::REG_STATUS, "status", 32'h0, 32'hF, 1'b1);
		for (int i = 0; i < 4; i++) begin
			a = 22'($urandom_range(22'h3FFFFF, 22'h008000));
			d = 16'($urandom);
			op(a, d, 1'b1);
			op(a, 16'h0000, 1'b0);
			rd(fsp_pkg::REG_RDATA, "data", {16'h0, d}, 32'hFFFF, 1'b1);
		end
		// Group 0: blocked, opened by elevated level, closed again, wp low.
		for (int i = 0; i < 4; i++) begin
			wr(fsp_pkg::REG_PINS, {29'h0, pins[i]});
			rd(fsp_pkg::REG_PINS, "pins", {29'h0, pins[i]}, 32'h7,
				1'b1);
			cmp("pin out", {29'h0, pins[i]},
				{29'h0, o_reset_n, o_wp, o_elev});
			d = 16'($urandom);
			// A fresh group 0 word while blocked, then one word kept.
			if (i < 2)
				a = {14'h0, d[7:0]};
			if (okw[i])
				d_ok = d;
			op(a, okw[i] ? d : 16'h1234, 1'b1);
			op(a, 16'h0000, 1'b0);
			rd(fsp_pkg::REG_RDATA, "group0",
				i == 0 ? 32'hFFFF : {16'h0, d_ok},
				32'hFFFF, 1'b1);
		end
		@(posedge i_clk);
		i_supply_low <= 1'b1;
		repeat (4) @(posedge i_clk);
		wr(fsp_pkg::REG_CTRL, 32'h2);
		repeat (8) @(posedge i_clk);
		rd(fsp_pkg::REG_STATUS, "refused", {28'h0, d_ok[7], 3'h6},
			32'hF, 1'b1);
		cmp("we pulses", 32'(exp_we), 32'(n_we));
		repeat (3) @(posedge i_clk);
		test_done();
	end
endmodule : fsp_ctrl_test

// File: testbench/fsp_flash_model.sv
// Behavioural flash device seen from the controller's pins.
`timescale 1ns/1ps
module fsp_flash_model (
	input  wire logic        i_ce_n,
	input  wire logic        i_we_n,
	input  wire logic        i_oe_n,
	input  wire logic [21:0] i_addr,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_elevated,
	input  wire logic        i_wp_n,
	input  wire logic        i_supply_low,
	output logic      [15:0] o_dq
);
	// ========================================================================
	// Array and protection
	logic [15:0] mem [int];
	logic [15:0] last_r;
	realtime     t_fall;
	logic        locked;
	initial last_r = 16'h0000;
	always @(negedge i_we_n) t_fall = $realtime;
	// The word read last is taken from the array, not from the output,
	// so the capture cannot race the output process.
	always @(posedge i_oe_n)
		last_r = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 16'hFFFF;
	always @(posedge i_we_n) begin
		if (!i_ce_n && i_oe_n && !i_supply_low
			&& $realtime - t_fall >= 3.0) begin
			// Group 0 is stored protected unless i_elevated and i_wp_n are both high.
			locked = i_addr[21:15] == 7'h00 && (!i_wp_n || !i_elevated);
			if (!locked)
				mem[int'(i_addr)] = i_dq;
		end
	end
	// A released bus shows the inverse of the last word, never a held value.
	always @* begin
		if (!i_ce_n && !i_oe_n)
			o_dq = mem.exists(int'(i_addr)) ? mem[int'(i_addr)]
				: 16'hFFFF;
		else
			o_dq = ~last_r;
	end
endmodule : fsp_flash_model
